// [core/fst_pkg.sv]
/*
 * fst_pkg: shared constants, enumerations and packed carriers of the
 * frame start trigger controller.
 * assumes: included first in compile order; no clocking of its own.
 */
package fst_pkg;

   // ----------------------------------------------------------------
   // trigger origins and modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      FST_SRC_SW    = 2'h0,
      FST_SRC_LINE1 = 2'h1,
      FST_SRC_LINE2 = 2'h2
   } fst_src_e;

   // acquisition style
   typedef enum logic
   {
      FST_ACQ_SINGLE = 1'h0,
      FST_ACQ_CONT   = 1'h1
   } fst_acq_e;

   // edge polarity of a line trigger
   typedef enum logic
   {
      FST_EDGE_RISE = 1'h0,
      FST_EDGE_FALL = 1'h1
   } fst_edge_e;

   // exposure timing source when a line origin is selected
   typedef enum logic
   {
      FST_EXP_TIMED = 1'h0,
      FST_EXP_WIDTH = 1'h1
   } fst_exp_e;

   // ----------------------------------------------------------------
   // reset values and widths
   // ----------------------------------------------------------------
   localparam int FST_PERIOD_W = 32;
   localparam fst_src_e FST_FRAME_SRC_RST = FST_SRC_LINE1;
   localparam fst_src_e FST_ACQ_SRC_RST = FST_SRC_LINE2;
   localparam logic [FST_PERIOD_W-1:0] FST_CNT_ONE = 32'h0000_0001;
   localparam logic [FST_PERIOD_W-1:0] FST_CNT_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // configuration carrier
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic trig_on;                  // external frame triggering enabled
      fst_src_e frame_src;            // frame start trigger origin
      fst_edge_e edge_sel;            // active edge of the line
      fst_acq_e acq_style;            // single frame or continuous
      logic rate_setpoint_enable;     // programmed internal rate in use
      fst_exp_e exp_src;              // line origin: timed or trigger width
   } fst_cfg_s;

endpackage

// [core/fst_sync.sv]
/*
 * fst_sync: two flop synchroniser followed by an edge detector.
 * assumes: async line input, one core clock, synchronous active low reset.
 */
`timescale 1ns/1ps
module fst_sync
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic line_in,
   output logic level_out,
   output logic rise_out,
   output logic fall_out
);
   import fst_pkg::*;

   // ----------------------------------------------------------------
   // synchroniser stages
   // ----------------------------------------------------------------
   logic meta_reg;   // first stage, read only by the second stage
   logic meta_next;
   logic sync_reg;   // second stage, safe to use
   logic sync_next;
   logic prev_reg;   // delayed copy for edge detection
   logic prev_next;

   // next values
   always_comb
   begin
      meta_next = line_in;
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   // registers
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   // edges from the settled stages only
   assign level_out = sync_reg;
   assign rise_out = sync_reg & ~prev_reg;
   assign fall_out = ~sync_reg & prev_reg;

endmodule

// [core/fst_rate_gen.sv]
/*
 * fst_rate_gen: periodic tick generator for internal frame triggers.
 * assumes: period counts in core clock cycles, at least one.
 */
`timescale 1ns/1ps
module fst_rate_gen
#(
   parameter int PERIOD_W = 32
)
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic run_in,
   input wire logic [PERIOD_W-1:0] period_in,
   output logic tick_out
);
   import fst_pkg::*;

   // elaboration check
   if (PERIOD_W < 2 || PERIOD_W > FST_PERIOD_W)
   begin : g_bad_width
      $error("fst_rate_gen: period width out of range");
   end

   logic [PERIOD_W-1:0] cnt_reg;   // cycles left until next tick
   logic [PERIOD_W-1:0] cnt_next;
   logic tick_reg;
   logic tick_next;

   // count down while running; first tick comes at once on start
   always_comb
   begin
      cnt_next = cnt_reg;
      tick_next = 1'b0;
      if (!run_in)
      begin
         cnt_next = '0;
      end
      else if (cnt_reg <= FST_CNT_ONE[PERIOD_W-1:0])
      begin
         tick_next = 1'b1;
         cnt_next = period_in;
      end
      else
      begin
         cnt_next = cnt_reg - FST_CNT_ONE[PERIOD_W-1:0];
      end
   end

   // registers
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick_out = tick_reg;

endmodule

// [core/fst_trigger_ctrl.sv]
/*
 * fst_trigger_ctrl: frame start trigger controller top.
 * assumes: all control bits are plain synchronous ports from a host
 * register block; acquisition status (waiting for frame start) comes from
 * the acquisition start state machine; maximum period comes from the frame
 * rate calculator; exposure logic lives downstream.
 * limitation: a fire command held high for several cycles acts once per cycle, and a begin
 * command held high in single style re-arms every second cycle, so the host must pulse them.
 */
// Summary of operation
// - one frame per accepted trigger while waiting
// - triggers outside waiting status are dropped
// - waiting needs style, begin command, start trigger
// - triggering off means triggers made internally
// - single style gives one trigger per begin
// - continuous style runs from begin until end
// - setpoint off runs at maximum permitted rate
// - setpoint on below maximum uses programmed rate
// - setpoint above maximum clamps to maximum rate
// - triggering off times exposure from shutter setting
// - triggering on accepts only selected origin
// - software origin: each fire command triggers
// - line origin: trigger taken from chosen line
// - edge polarity selects rising or falling edge
// - reset selects line 1 frame, line 2 start
// - software origin times exposure from shutter setting
// - line origin: shutter setting or trigger width
`timescale 1ns/1ps
module fst_trigger_ctrl
#(
   parameter int PERIOD_W = 32
)
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire fst_pkg::fst_cfg_s cfg_in,
   input wire logic cfg_load_in,
   input wire logic acq_begin_in,
   input wire logic acq_end_in,
   input wire logic sw_fire_in,
   input wire logic waiting_in,
   input wire logic [PERIOD_W-1:0] max_period_in,
   input wire logic [PERIOD_W-1:0] set_period_in,
   input wire logic line1_in,
   input wire logic line2_in,
   output logic frame_start_out,
   output logic ignored_out,
   output logic running_out,
   output logic exp_timed_out,
   output logic exp_width_out,
   output logic exp_level_out,
   output fst_pkg::fst_src_e frame_src_out,
   output fst_pkg::fst_src_e acq_src_out
);
   import fst_pkg::*;

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (PERIOD_W < 2 || PERIOD_W > FST_PERIOD_W)
   begin : g_bad_width
      $error("fst_trigger_ctrl: period width out of range");
   end

   // ----------------------------------------------------------------
   // configuration register
   // ----------------------------------------------------------------
   fst_cfg_s cfg_reg;   // live configuration
   fst_cfg_s cfg_next;
   fst_src_e acq_src_reg;   // acquisition start origin, fixed by reset
   fst_src_e acq_src_next;

   // a whole setting is taken at once, so origin, edge and exposure
   // source can never be seen half changed by the logic below
   // load a new setting on the strobe
   always_comb
   begin
      cfg_next = cfg_reg;
      acq_src_next = acq_src_reg;
      if (cfg_load_in)
      begin
         cfg_next = cfg_in;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         // origins fall back to line one for frames, line two for starts
         cfg_reg <= '{trig_on: 1'b0, frame_src: FST_FRAME_SRC_RST, edge_sel: FST_EDGE_RISE,
                      acq_style: FST_ACQ_SINGLE, rate_setpoint_enable: 1'b0, exp_src: FST_EXP_TIMED};
         acq_src_reg <= FST_ACQ_SRC_RST;
      end
      else
      begin
         cfg_reg <= cfg_next;
         acq_src_reg <= acq_src_next;
      end
   end

   // ----------------------------------------------------------------
   // line synchronisers
   // ----------------------------------------------------------------
   // both lines are always synchronised, so changing the origin
   // never exposes a half-settled level to the edge logic
   logic l1_level;
   logic l1_rise;
   logic l1_fall;
   logic l2_level;
   logic l2_rise;
   logic l2_fall;

   fst_sync u_sync_l1
   (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .line_in(line1_in),
      .level_out(l1_level),
      .rise_out(l1_rise),
      .fall_out(l1_fall)
   );

   // line two has its own synchroniser, never a copy of line one
   // physical line two
   fst_sync u_sync_l2
   (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .line_in(line2_in),
      .level_out(l2_level),
      .rise_out(l2_rise),
      .fall_out(l2_fall)
   );

   // ----------------------------------------------------------------
   // internal generator run state
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      FST_IDLE = 2'h0,
      FST_ONE  = 2'h1,
      FST_RUN  = 2'h2
   } fst_gen_e;

   fst_gen_e gen_reg;   // internal generator state
   fst_gen_e gen_next;
   logic [PERIOD_W-1:0] period_reg;   // chosen internal period
   logic [PERIOD_W-1:0] period_next;
   logic gen_tick;   // tick from the rate generator
   logic int_fire;   // internal trigger candidate

   // the period is resampled every cycle, so a new maximum takes effect
   // at the next tick without a restart
   // choose the period: longer period means lower rate
   always_comb
   begin
      period_next = max_period_in;
      if (cfg_reg.rate_setpoint_enable && set_period_in > max_period_in)
      begin
         period_next = set_period_in;
      end
      else
      begin
         period_next = max_period_in;
      end
      // never below one cycle
      // a zero period would tick every cycle, the same as a period of one
      if (period_next == '0)
      begin
         period_next = FST_CNT_ONE[PERIOD_W-1:0];
      end
   end

   // generator state: single waits for its one accepted trigger
   always_comb
   begin
      gen_next = gen_reg;
      unique case (gen_reg)
         FST_IDLE:
         begin
            // idle: wait for a begin command with triggering off
            // start on begin command
            if (acq_begin_in && !cfg_reg.trig_on)
            begin
               gen_next = (cfg_reg.acq_style == FST_ACQ_CONT) ? FST_RUN : FST_ONE;
            end
         end
         FST_ONE:
         begin
            if (int_fire && waiting_in)
            begin
               gen_next = FST_IDLE;
            end
            // an end command or triggering on abandons the pending trigger
            else if (acq_end_in || cfg_reg.trig_on)
            begin
               gen_next = FST_IDLE;
            end
         end
         FST_RUN:
         begin
            // run until end command
            // switching triggering on also stops the generator
            if (acq_end_in || cfg_reg.trig_on)
            begin
               gen_next = FST_IDLE;
            end
         end
         default:
         begin
            // unused code: recover to idle
            gen_next = FST_IDLE;
         end
      endcase
   end

   // the generator only counts while a trigger is pending or running,
   // so each start gives its first tick straight away
   // internal tick source
   fst_rate_gen #(.PERIOD_W(PERIOD_W)) u_rate
   (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .run_in(gen_reg == FST_RUN || gen_reg == FST_ONE),
      .period_in(period_reg),
      .tick_out(gen_tick)
   );

   // single style fires as soon as waiting; continuous on each tick
   assign int_fire = (gen_reg == FST_ONE) ? 1'b1 : (gen_reg == FST_RUN) & gen_tick;

   // ----------------------------------------------------------------
   // external origin selection and acceptance
   // ----------------------------------------------------------------
   logic ext_fire;   // edge or command from selected origin
   logic sel_level;   // active-high level of selected line
   logic cand;
   logic frame_next;
   logic ign_next;

   // pick the candidate of the selected origin; the other line is
   // synchronised but never reaches acceptance
   always_comb
   begin
      ext_fire = 1'b0;
      sel_level = 1'b0;
      unique case (cfg_reg.frame_src)
         FST_SRC_SW:
         begin
            ext_fire = sw_fire_in;
         end
         FST_SRC_LINE1:
         begin
            ext_fire = (cfg_reg.edge_sel == FST_EDGE_FALL) ? l1_fall : l1_rise;
            sel_level = l1_level ^ (cfg_reg.edge_sel == FST_EDGE_FALL);
         end
         FST_SRC_LINE2:
         begin
            ext_fire = (cfg_reg.edge_sel == FST_EDGE_FALL) ? l2_fall : l2_rise;
            sel_level = l2_level ^ (cfg_reg.edge_sel == FST_EDGE_FALL);
         end
         default:
         begin
            ext_fire = 1'b0;
         end
      endcase
   end

   // only the selected origin when on
   assign cand = cfg_reg.trig_on ? ext_fire : int_fire;

   // internal candidates are not reported as dropped: a pending single
   // trigger simply waits for the status, a running one is rate paced
   // accept only while waiting
   always_comb
   begin
      frame_next = cand & waiting_in;
      ign_next = cand & ~waiting_in & cfg_reg.trig_on;
   end

   // ----------------------------------------------------------------
   // exposure source and output registers
   // ----------------------------------------------------------------
   // exposure source is a level that follows the setting; width mode
   // also hands on the active level of the chosen line
   logic timed_next;
   logic width_next;
   logic level_next;

   always_comb
   begin
      timed_next = !cfg_reg.trig_on || cfg_reg.frame_src == FST_SRC_SW ||
                   cfg_reg.exp_src == FST_EXP_TIMED;
      width_next = !timed_next;
      level_next = width_next & sel_level;
   end

   // output registers: every output leaves a flip-flop, which costs
   // one cycle of latency on each trigger but keeps downstream timing clean
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         gen_reg <= FST_IDLE;
         period_reg <= FST_CNT_ONE[PERIOD_W-1:0];
         frame_start_out <= 1'b0;
         ignored_out <= 1'b0;
         running_out <= 1'b0;
         // triggering is off after reset, so exposure starts timed
         exp_timed_out <= 1'b1;
         exp_width_out <= 1'b0;
         exp_level_out <= 1'b0;
         frame_src_out <= FST_FRAME_SRC_RST;
         acq_src_out <= FST_ACQ_SRC_RST;
      end
      else
      begin
         gen_reg <= gen_next;
         period_reg <= period_next;
         frame_start_out <= frame_next;
         ignored_out <= ign_next;
         // running shows the state being entered, not the one left
         running_out <= (gen_next != FST_IDLE);
         exp_timed_out <= timed_next;
         exp_width_out <= width_next;
         exp_level_out <= level_next;
         frame_src_out <= cfg_reg.frame_src;
         acq_src_out <= acq_src_reg;
      end
   end

endmodule

// [verif/fst_host_src.sv]
/*
 * fst_host_src: far side model, host fire commands and two trigger lines.
 * assumes: bench calls its tasks; all changes land on falling edges.
 */
`timescale 1ns/1ps
module fst_host_src
(
   input wire logic sys_clk_in,
   output logic sw_fire_out,
   output logic line1_out,
   output logic line2_out
);
   // lines are driven levels, never released, so no idle pattern is needed
   initial
   begin
      sw_fire_out = 1'b0;
      line1_out = 1'b0;
      line2_out = 1'b0;
   end
   // one fire command gives one trigger, one cycle wide
   task automatic fire();
      @(negedge sys_clk_in);
      sw_fire_out = 1'b1;
      @(negedge sys_clk_in);
      sw_fire_out = 1'b0;
   endtask
   // level held long enough to pass the synchroniser
   task automatic set_line(input int n, input logic v);
      @(negedge sys_clk_in);
      if (n == 1)
         line1_out = v;
      else
         line2_out = v;
      repeat (6) @(negedge sys_clk_in);
   endtask
endmodule

// [verif/fst_trigger_ctrl_chk.sv]
/*
 * fst_trigger_ctrl_chk: port assertions of the trigger controller.
 * assumes: bound to fst_trigger_ctrl; one clock, sync low reset.
 */
`timescale 1ns/1ps
module fst_trigger_ctrl_chk
#(
   parameter int PERIOD_W = 32
)
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire fst_pkg::fst_cfg_s cfg_in,
   input wire logic cfg_load_in,
   input wire logic acq_end_in,
   input wire logic sw_fire_in,
   input wire logic waiting_in,
   input wire logic frame_start_out,
   input wire logic ignored_out,
   input wire logic running_out,
   input wire logic exp_timed_out,
   input wire logic exp_width_out,
   input wire fst_pkg::fst_src_e frame_src_out,
   input wire fst_pkg::fst_src_e acq_src_out
);
   import fst_pkg::*;
   // ----------------------------------------
   // shadow of the loaded configuration
   // ----------------------------------------
   fst_cfg_s cfg_reg; // last loaded setting
   fst_cfg_s cfg_next;
   logic [1:0] age_reg; // cycles since load, saturates at 3
   logic [1:0] age_next;
   logic settled; // level outputs have had time to follow
   // outputs lag a load by up to two cycles, so wait three
   always_comb
   begin
      cfg_next = cfg_load_in ? cfg_in : cfg_reg;
      age_next = cfg_load_in ? 2'h0 : ((age_reg == 2'h3) ? age_reg : age_reg + 2'h1);
   end
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_b_in)
      begin
         cfg_reg <= '0;
         cfg_reg.frame_src <= FST_FRAME_SRC_RST;
         age_reg <= 2'h0;
      end
      else
      begin
         cfg_reg <= cfg_next;
         age_reg <= age_next;
      end
   end
   assign settled = (age_reg == 2'h3);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking dc @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   frame_needs_wait_a: assert property (frame_start_out |-> $past(waiting_in))
      else $error("frame start outside waiting status");
   drop_not_wait_a: assert property (ignored_out |-> !$past(waiting_in) && !frame_start_out)
      else $error("trigger dropped while waiting");
   sw_fire_frame_a: assert property (settled && cfg_reg.trig_on && frame_src_out == FST_SRC_SW
      && sw_fire_in && waiting_in |=> frame_start_out)
      else $error("fire command gave no frame start");
   reset_origin_a: assert property ($rose(rst_b_in) |-> frame_src_out == FST_SRC_LINE1 && !running_out)
      else $error("frame origin after reset wrong");
   acq_origin_a: assert property (acq_src_out == FST_ACQ_SRC_RST)
      else $error("acquisition origin not line two");
   timed_off_a: assert property (settled && !cfg_reg.trig_on |-> exp_timed_out && !exp_width_out)
      else $error("exposure not timed with triggering off");
   timed_soft_a: assert property (settled && cfg_reg.trig_on && cfg_reg.frame_src == FST_SRC_SW |-> exp_timed_out)
      else $error("exposure not timed with software origin");
   width_line_a: assert property (settled && cfg_reg.trig_on && cfg_reg.frame_src != FST_SRC_SW
      |-> exp_width_out == (cfg_reg.exp_src == FST_EXP_WIDTH))
      else $error("exposure source of line origin wrong");
   origin_follow_a: assert property (settled |-> frame_src_out == cfg_reg.frame_src)
      else $error("frame origin does not follow setting");
   stop_gen_a: assert property (acq_end_in |-> ##[1:2] !running_out)
      else $error("generator still running after end");
   cover property (frame_start_out && frame_src_out == FST_SRC_LINE2);
   cover property (ignored_out);
   cover property ($rose(running_out));
endmodule
bind fst_trigger_ctrl fst_trigger_ctrl_chk #(.PERIOD_W(PERIOD_W)) chk_u
(
   .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .cfg_in(cfg_in), .cfg_load_in(cfg_load_in),
   .acq_end_in(acq_end_in), .sw_fire_in(sw_fire_in), .waiting_in(waiting_in),
   .frame_start_out(frame_start_out), .ignored_out(ignored_out), .running_out(running_out),
   .exp_timed_out(exp_timed_out), .exp_width_out(exp_width_out),
   .frame_src_out(frame_src_out), .acq_src_out(acq_src_out)
);

// [verif/fst_trigger_ctrl_test.sv]
/*
 * fst_trigger_ctrl_test: directed bench of the trigger controller.
 * assumes: fst_host_src as far side; checker bound in its own file.
 */
`timescale 1ns/1ps
module fst_trigger_ctrl_test;
   import fst_pkg::*;
   logic sys_clk_in, rst_b_in, cfg_load_in, acq_begin_in, acq_end_in, waiting_in;
   logic sw_fire, line1, line2; // from the far side model
   fst_cfg_s cfg_in;
   logic [31:0] max_period_in, set_period_in;
   logic frame_start_out, ignored_out, running_out, exp_timed_out, exp_width_out, exp_level_out;
   fst_src_e frame_src_out, acq_src_out;
   int failures = 0, check_count = 0, frame_cnt = 0, cyc = 0, last_cyc = 0, gap = 0;
   fst_host_src src_u (.sys_clk_in(sys_clk_in), .sw_fire_out(sw_fire), .line1_out(line1), .line2_out(line2));
   fst_trigger_ctrl dut_u
   (
      .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .cfg_in(cfg_in), .cfg_load_in(cfg_load_in),
      .acq_begin_in(acq_begin_in), .acq_end_in(acq_end_in), .sw_fire_in(sw_fire),
      .waiting_in(waiting_in), .max_period_in(max_period_in), .set_period_in(set_period_in),
      .line1_in(line1), .line2_in(line2), .frame_start_out(frame_start_out),
      .ignored_out(ignored_out), .running_out(running_out), .exp_timed_out(exp_timed_out),
      .exp_width_out(exp_width_out), .exp_level_out(exp_level_out),
      .frame_src_out(frame_src_out), .acq_src_out(acq_src_out)
   );
   // 40 MHz clock
   initial
   begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   // frame counter and spacing between the last two frames
   always @(posedge sys_clk_in)
   begin
      cyc++;
      if (frame_start_out === 1'b1)
      begin
         gap = cyc - last_cyc;
         last_cyc = cyc;
         frame_cnt++;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic fst_cfg_s mk(logic t, fst_src_e s, fst_edge_e e, fst_acq_e a, logic r, fst_exp_e x);
      return '{t, s, e, a, r, x};
   endfunction
   // load a setting, then let the level outputs follow
   task automatic load(input fst_cfg_s c);
      @(negedge sys_clk_in);
      cfg_in = c;
      cfg_load_in = 1'b1;
      @(negedge sys_clk_in);
      cfg_load_in = 1'b0;
      repeat (3) @(negedge sys_clk_in);
   endtask
   // one begin or end command pulse
   task automatic cmd(input bit stop);
      @(negedge sys_clk_in);
      acq_begin_in = !stop;
      acq_end_in = stop;
      @(negedge sys_clk_in);
      acq_begin_in = 1'b0;
      acq_end_in = 1'b0;
   endtask
   task automatic t_reset();
      chk(frame_src_out, FST_FRAME_SRC_RST);
      chk(acq_src_out, FST_ACQ_SRC_RST);
      chk({exp_timed_out, running_out}, 2'h2);
      $display("test reset done");
   endtask
   task automatic t_soft();
      load(mk(1'b1, FST_SRC_SW, FST_EDGE_RISE, FST_ACQ_SINGLE, 1'b0, FST_EXP_WIDTH));
      frame_cnt = 0;
      src_u.fire();
      chk(frame_start_out, 1'h1);
      src_u.fire();
      src_u.fire();
      chk(exp_timed_out, 1'h1);
      waiting_in = 1'b0;
      src_u.fire();
      chk({ignored_out, frame_start_out}, 2'h2);
      waiting_in = 1'b1;
      src_u.set_line(1, 1'b1);
      src_u.set_line(1, 1'b0);
      chk(frame_cnt, 3);
      $display("test software done");
   endtask
   task automatic t_line();
      fst_src_e s;
      fst_edge_e e;
      fst_exp_e x;
      for (int i = 0; i < 4; i++)
      begin
         s = (i < 2) ? FST_SRC_LINE1 : FST_SRC_LINE2;
         e = fst_edge_e'(i % 2);
         x = fst_exp_e'(i != 3);
         src_u.set_line(1, e);
         src_u.set_line(2, e);
         load(mk(1'b1, s, e, FST_ACQ_SINGLE, 1'b0, x));
         chk({frame_src_out, exp_width_out, exp_timed_out}, {s, x, !x});
         frame_cnt = 0;
         src_u.set_line(3 - int'(s), !e);
         chk(frame_cnt, 0);
         src_u.set_line(int'(s), !e);
         chk(frame_cnt, 1);
         chk(exp_level_out, x);
         src_u.set_line(int'(s), e);
         chk(frame_cnt, 1);
         chk(exp_level_out, 1'h0);
      end
      $display("test lines done");
   endtask
   task automatic t_single();
      load(mk(1'b0, FST_SRC_SW, FST_EDGE_RISE, FST_ACQ_SINGLE, 1'b0, FST_EXP_WIDTH));
      frame_cnt = 0;
      repeat (10) @(negedge sys_clk_in);
      chk(frame_cnt, 0);
      cmd(1'b0);
      repeat (30) @(negedge sys_clk_in);
      chk(frame_cnt, 1);
      chk(exp_timed_out, 1'h1);
      $display("test single done");
   endtask
   task automatic t_cont();
      logic en [3] = '{1'b0, 1'b1, 1'b1};
      int setp [3] = '{10, 10, 2};
      int exp [3] = '{4, 10, 4};
      for (int i = 0; i < 3; i++)
      begin
         load(mk(1'b0, FST_SRC_SW, FST_EDGE_RISE, FST_ACQ_CONT, en[i], FST_EXP_TIMED));
         set_period_in = setp[i];
         cmd(1'b0);
         repeat (40) @(negedge sys_clk_in);
         chk(running_out, 1'h1);
         chk(gap, exp[i]);
         waiting_in = 1'b0;
         frame_cnt = 0;
         repeat (12) @(negedge sys_clk_in);
         chk(frame_cnt, 0);
         waiting_in = 1'b1;
         cmd(1'b1);
         repeat (3) @(negedge sys_clk_in);
         frame_cnt = 0;
         repeat (20) @(negedge sys_clk_in);
         chk({running_out, frame_cnt[7:0]}, 9'h0);
      end
      $display("test continuous done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // watchdog: the run needs well under 2000 cycles
   initial
   begin
      repeat (5000) @(posedge sys_clk_in);
      failures++;
      report_and_stop();
   end
   initial
   begin
      rst_b_in = 1'b0;
      cfg_in = '0;
      {cfg_load_in, acq_begin_in, acq_end_in} = 3'h0;
      // the waiting status comes from outside
      waiting_in = 1'b1;
      max_period_in = 32'h4;
      set_period_in = 32'h4;
      repeat (2) @(negedge sys_clk_in);
      rst_b_in = 1'b1;
      @(negedge sys_clk_in);
      t_reset();
      t_soft();
      t_line();
      t_single();
      t_cont();
      report_and_stop();
   end
endmodule
